// >>> rtl/read_stream_command_control.v
// Contract
// - urgent bit asks fastest finish within limit
// - continuous mode never aborts on sector errors
// - continuous errors: full transfer, SE set, logged
// - continuous timeout: halt, SE set, CCTO logged
// - always try full amount within limit
// - continuous clear: normal streaming error handling
// - handle-stream-error resumes earlier recovery
// - low three feature bits pick stream
// - limit is previous feature times unit
// - zero uses stream default, else none
// - timed from command write to interrupt
// - limit below minimum raised to minimum
// - 16-bit count, zero means 65536
// - 48-bit LBA from three register pairs
// - error LBA loaded, HOB selects byte
// - error bit 0 flags timeout
// - SE set, regs hold LBA and run
// - continuous errors clear ERR, go to log
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "read_stream_defs.vh"
module read_stream_command_control #(
	parameter [23:0] MIN_CCTL_US = `MIN_CCTL_US_DEF
) (
	input wire clk,
	input wire reset,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire sector_ok,
	input wire sector_err,
	input wire [3:0] err_kind,
	output reg xfer_active,
	output reg xfer_abort,
	output reg [47:0] xfer_lba,
	output reg [16:0] xfer_sectors,
	output reg [2:0] stream_id,
	output reg urgent,
	output reg continuous,
	output reg not_sequential,
	output reg resume_recovery,
	output reg intrq
);
	localparam [1:0] S_IDLE = 2'd0;
	localparam [1:0] S_RUN = 2'd1;
	localparam [1:0] S_FIN = 2'd2;

	reg [1:0] state_q;
	reg wr_q;
	reg [7:0] wa_q;
	reg [7:0] feat_cur_q, feat_prv_q, cnt_cur_q, cnt_prv_q;
	reg [7:0] la_cur_q, la_prv_q;
	reg [7:0] lb_cur_q, lb_prv_q;
	reg [7:0] lc_cur_q, lc_prv_q;
	reg [7:0] dev_q, err_q, log_q;
	reg hob_q, bsy_q, se_q, errb_q;
	reg prev_bad_q, run_open_q, lim_en_q;
	reg [15:0] unit_q;
	reg [7:0] dflt_q [0:7];
	reg [16:0] remain_q;
	reg [15:0] bad_cnt_q;
	reg [47:0] fail_lba_q;
	reg [23:0] lim_q, us_cnt_q;
	reg [4:0] div_q;
	reg [31:0] rd_val;
	reg [7:0] req_cctl;
	reg [23:0] lim_raw;
	integer i;

	// only the address phase is taken here; its data phase follows through wr_q
	wire take = hsel && hready && htrans[1];
	wire [7:0] ra = haddr[7:0];
	wire us_tick = (div_q == (`US_CYCLES - 1));
	wire [47:0] start_lba = {lc_prv_q, lb_prv_q, la_prv_q, lc_cur_q, lb_cur_q, la_cur_q};
	wire [15:0] cnt16 = {cnt_prv_q, cnt_cur_q};
	wire sector = sector_ok || sector_err;
	// whole microseconds keep the timer narrow at the cost of one microsecond of grain
	wire timed_out = lim_en_q && (us_cnt_q >= lim_q);

	// word aligned decode of the low address byte
	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a[7:2] == off[7:2]);
		end
	endfunction

	function [7:0] pick;
		input h;
		input [7:0] cur;
		input [7:0] prv;
		begin
			pick = h ? prv : cur;
		end
	endfunction

	// a zero count asks for the largest transfer
	function [16:0] sectors_of;
		input [15:0] c;
		begin
			sectors_of = (c == 16'h0000) ? `SECT_MAX : {1'b0, c};
		end
	endfunction

	// error register and log share one bit layout
	function [7:0] kind_bits;
		input [3:0] k;
		begin
			kind_bits = 8'h00;
			kind_bits[`ERR_ICRC] = k[3];
			kind_bits[`ERR_UNC] = k[2];
			kind_bits[`ERR_IDNF] = k[1];
			kind_bits[`ERR_ABRT] = k[0];
		end
	endfunction

	always @* begin
		// zero previous byte falls back to the stream default
		req_cctl = (feat_prv_q != 8'h00) ? feat_prv_q : dflt_q[feat_cur_q[2:0]];
		// widened on purpose: an 8 by 16 bit product never wraps in 24 bits
		lim_raw = {16'h0000, req_cctl} * {8'h00, unit_q};
		if (lim_raw < MIN_CCTL_US) begin
			lim_raw = MIN_CCTL_US;
		end
	end

	always @* begin
		// unmapped offsets read as zero
		rd_val = 32'h0000_0000;
		if (hit(ra, `OFF_FEATURE)) begin
			rd_val[7:0] = pick(hob_q, feat_cur_q, feat_prv_q);
		end else if (hit(ra, `OFF_SEC_COUNT)) begin
			rd_val[7:0] = pick(hob_q, cnt_cur_q, cnt_prv_q);
		end else if (hit(ra, `OFF_LBA_A)) begin
			rd_val[7:0] = pick(hob_q, la_cur_q, la_prv_q);
		end else if (hit(ra, `OFF_LBA_B)) begin
			rd_val[7:0] = pick(hob_q, lb_cur_q, lb_prv_q);
		end else if (hit(ra, `OFF_LBA_C)) begin
			rd_val[7:0] = pick(hob_q, lc_cur_q, lc_prv_q);
		end else if (hit(ra, `OFF_DEV_HEAD)) begin
			rd_val[7:0] = dev_q;
		end else if (hit(ra, `OFF_DEV_CTL)) begin
			rd_val[`HOB_BIT] = hob_q;
		end else if (hit(ra, `OFF_ERROR)) begin
			rd_val[7:0] = err_q;
		end else if (hit(ra, `OFF_STATUS) || hit(ra, `OFF_DATA_CMD)) begin
			rd_val[`ST_BSY] = bsy_q;
			rd_val[`ST_RDY] = 1'b1;
			rd_val[`ST_SE] = se_q;
			rd_val[`ST_ERR] = errb_q;
		end else if (hit(ra, `OFF_TIME_UNIT)) begin
			rd_val[15:0] = unit_q;
		end else if (hit(ra, `OFF_ERR_LOG)) begin
			rd_val[7:0] = log_q;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			state_q <= S_IDLE;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			feat_cur_q <= 8'h00;
			feat_prv_q <= 8'h00;
			cnt_cur_q <= 8'h00;
			cnt_prv_q <= 8'h00;
			la_cur_q <= 8'h00;
			la_prv_q <= 8'h00;
			lb_cur_q <= 8'h00;
			lb_prv_q <= 8'h00;
			lc_cur_q <= 8'h00;
			lc_prv_q <= 8'h00;
			dev_q <= 8'h00;
			err_q <= 8'h00;
			log_q <= 8'h00;
			hob_q <= 1'b0;
			bsy_q <= 1'b0;
			se_q <= 1'b0;
			errb_q <= 1'b0;
			prev_bad_q <= 1'b0;
			run_open_q <= 1'b0;
			lim_en_q <= 1'b0;
			unit_q <= `TIME_UNIT_RST;
			for (i = 0; i < 8; i = i + 1) begin
				dflt_q[i] <= 8'h00;
			end
			remain_q <= 17'h00000;
			bad_cnt_q <= 16'h0000;
			fail_lba_q <= 48'h0000_0000_0000;
			lim_q <= 24'h000000;
			us_cnt_q <= 24'h000000;
			div_q <= 5'h00;
			xfer_active <= 1'b0;
			xfer_abort <= 1'b0;
			xfer_lba <= 48'h0000_0000_0000;
			xfer_sectors <= 17'h00000;
			stream_id <= 3'h0;
			urgent <= 1'b0;
			continuous <= 1'b0;
			not_sequential <= 1'b0;
			resume_recovery <= 1'b0;
			intrq <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			xfer_abort <= 1'b0;
			wr_q <= take && hwrite;
			if (take) begin
				wa_q <= ra;
			end
			// read data is caught in the address phase, so the bus never waits
			if (take && !hwrite) begin
				hrdata <= rd_val;
			end
			// reading status acknowledges the interrupt
			if (take && !hwrite && hit(ra, `OFF_STATUS)) begin
				intrq <= 1'b0;
			end
			// host side writes; the shadow registers stay frozen while busy
			if (wr_q && hit(wa_q, `OFF_DEV_CTL)) begin
				// the byte select is taken even while busy, so either byte of a shadow register can be read back
				hob_q <= hwdata[`HOB_BIT];
			end else if (wr_q && !bsy_q) begin
				if (hit(wa_q, `OFF_FEATURE)) begin
					feat_prv_q <= feat_cur_q;
					feat_cur_q <= hwdata[7:0];
				end else if (hit(wa_q, `OFF_SEC_COUNT)) begin
					cnt_prv_q <= cnt_cur_q;
					cnt_cur_q <= hwdata[7:0];
				end else if (hit(wa_q, `OFF_LBA_A)) begin
					la_prv_q <= la_cur_q;
					la_cur_q <= hwdata[7:0];
				end else if (hit(wa_q, `OFF_LBA_B)) begin
					lb_prv_q <= lb_cur_q;
					lb_cur_q <= hwdata[7:0];
				end else if (hit(wa_q, `OFF_LBA_C)) begin
					lc_prv_q <= lc_cur_q;
					lc_cur_q <= hwdata[7:0];
				end else if (hit(wa_q, `OFF_DEV_HEAD)) begin
					dev_q <= hwdata[7:0];
				end else if (hit(wa_q, `OFF_TIME_UNIT)) begin
					unit_q <= hwdata[15:0];
				end else if (hit(wa_q, `OFF_STREAM_CFG)) begin
					dflt_q[hwdata[10:8]] <= hwdata[7:0];
				end else if (hit(wa_q, `OFF_DATA_CMD) && hwdata[7:0] == `OPC_READ_STREAM_PIO
						&& dev_q[7:5] == `DEV_FIXED_ONES) begin
					// a wrong opcode or device field leaves the command unseen
					state_q <= S_RUN;
					bsy_q <= 1'b1;
					se_q <= 1'b0;
					errb_q <= 1'b0;
					err_q <= 8'h00;
					log_q <= 8'h00;
					intrq <= 1'b0;
					prev_bad_q <= 1'b0;
					run_open_q <= 1'b0;
					bad_cnt_q <= 16'h0000;
					remain_q <= sectors_of(cnt16);
					xfer_sectors <= sectors_of(cnt16);
					xfer_lba <= start_lba;
					fail_lba_q <= start_lba;
					stream_id <= feat_cur_q[2:0];
					urgent <= feat_cur_q[`FEAT_URG];
					continuous <= feat_cur_q[`FEAT_RC];
					not_sequential <= feat_cur_q[`FEAT_NS];
					resume_recovery <= feat_cur_q[`FEAT_HSE];
					lim_en_q <= (req_cctl != 8'h00);
					lim_q <= lim_raw;
					// the clock starts at the command write itself
					us_cnt_q <= 24'h000000;
					div_q <= 5'h00;
					xfer_active <= 1'b1;
				end
			end
			case (state_q)
				S_IDLE: begin
					// the divider rests between commands
					div_q <= 5'h00;
				end
				S_RUN: begin
					if (us_tick) begin
						div_q <= 5'h00;
						us_cnt_q <= us_cnt_q + 24'h000001;
					end else begin
						div_q <= div_q + 5'h01;
					end
					if (sector) begin
						xfer_lba <= xfer_lba + 48'h0000_0000_0001;
						remain_q <= remain_q - 17'h00001;
						prev_bad_q <= sector_err;
					end
					if (sector_err && continuous) begin
						log_q <= log_q | kind_bits(err_kind);
						if (!se_q) begin
							se_q <= 1'b1;
							fail_lba_q <= xfer_lba;
							bad_cnt_q <= 16'h0001;
							run_open_q <= 1'b1;
						end else if (run_open_q && prev_bad_q) begin
							bad_cnt_q <= bad_cnt_q + 16'h0001;
						end
					end
					if (sector_ok && se_q) begin
						// only the first run of bad sectors is reported
						run_open_q <= 1'b0;
					end
					// the timeout wins over a sector error in the same cycle
					if (timed_out) begin
						xfer_abort <= 1'b1;
						xfer_active <= 1'b0;
						state_q <= S_FIN;
						if (continuous) begin
							se_q <= 1'b1;
							log_q[`ERR_CCTO] <= 1'b1;
						end else begin
							errb_q <= 1'b1;
							err_q[`ERR_CCTO] <= 1'b1;
						end
					end else if (sector_err && !continuous) begin
						// normal streaming: stop at the failing sector
						errb_q <= 1'b1;
						err_q <= err_q | kind_bits(err_kind);
						fail_lba_q <= xfer_lba;
						xfer_abort <= 1'b1;
						xfer_active <= 1'b0;
						state_q <= S_FIN;
					end else if (sector && remain_q == 17'h00001) begin
						// continuous mode rides through errors to the full count
						xfer_active <= 1'b0;
						state_q <= S_FIN;
					end
				end
				S_FIN: begin
					// busy still blocks host writes while the shadow registers load
					if (se_q || errb_q) begin
						la_cur_q <= fail_lba_q[7:0];
						lb_cur_q <= fail_lba_q[15:8];
						lc_cur_q <= fail_lba_q[23:16];
						la_prv_q <= fail_lba_q[31:24];
						lb_prv_q <= fail_lba_q[39:32];
						lc_prv_q <= fail_lba_q[47:40];
					end
					if (se_q) begin
						cnt_cur_q <= bad_cnt_q[7:0];
						cnt_prv_q <= bad_cnt_q[15:8];
					end
					bsy_q <= 1'b0;
					intrq <= 1'b1;
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule // read_stream_command_control

// >>> rtl/read_stream_defs.vh
`ifndef READ_STREAM_DEFS_VH
`define READ_STREAM_DEFS_VH
`define OFF_DATA_CMD 8'h00
`define OFF_FEATURE 8'h04
`define OFF_SEC_COUNT 8'h08
`define OFF_LBA_A 8'h0c
`define OFF_LBA_B 8'h10
`define OFF_LBA_C 8'h14
`define OFF_DEV_HEAD 8'h18
`define OFF_DEV_CTL 8'h1c
`define OFF_ERROR 8'h20
`define OFF_STATUS 8'h24
`define OFF_TIME_UNIT 8'h28
`define OFF_STREAM_CFG 8'h2c
`define OFF_ERR_LOG 8'h30
`define OPC_READ_STREAM_PIO 8'h2b
`define DEV_FIXED_ONES 3'h7
`define HOB_BIT 7
`define FEAT_URG 7
`define FEAT_RC 6
`define FEAT_NS 5
`define FEAT_HSE 4
`define ERR_ICRC 7
`define ERR_UNC 6
`define ERR_IDNF 4
`define ERR_ABRT 2
`define ERR_CCTO 0
`define ST_BSY 7
`define ST_RDY 6
`define ST_SE 5
`define ST_ERR 0
`define TIME_UNIT_RST 16'h0001
`define CLK_MHZ 25
`define US_CYCLES (`CLK_MHZ)
`define MIN_CCTL_US_DEF 24'h0003e8
`define SECT_MAX 17'h10000
`endif

// >>> verif/media_model.sv
`timescale 1ns/1ps
module media_model (
	input wire clk,
	input wire reset,
	input wire xfer_active,
	input wire [7:0] gap,
	input wire [16:0] bad_lo,
	input wire [16:0] bad_hi,
	input wire [3:0] kind,
	output reg sector_ok,
	output reg sector_err,
	output reg [3:0] err_kind
);
	reg [7:0] wait_q;
	reg [16:0] num_q;
	// gap 0 stalls the media for good, so only a time-limit expiry can end the command
	always @(posedge clk) begin
		sector_ok <= 1'h0;
		sector_err <= 1'h0;
		// stale code toggles every cycle, so it never holds steady between errors
		err_kind <= reset ? 4'h0 : ~err_kind;
		if (reset || !xfer_active) begin
			wait_q <= 8'h0;
			num_q <= 17'h0;
		end else if (gap != 8'h0 && wait_q + 8'h1 == gap) begin
			wait_q <= 8'h0;
			num_q <= num_q + 17'h1;
			if (num_q >= bad_lo && num_q < bad_hi) begin
				sector_err <= 1'h1;
				err_kind <= kind;
			end else
				sector_ok <= 1'h1;
		end else
			wait_q <= wait_q + 8'h1;
	end
endmodule // media_model

// >>> verif/read_stream_command_control_asserts.sv
`timescale 1ns/1ps
module rscc_asserts #(
	parameter [23:0] MIN_CCTL_US = 24'h0003e8
) (
	input wire clk,
	input wire reset,
	input wire hreadyout,
	input wire hresp,
	input wire sector_ok,
	input wire sector_err,
	input wire xfer_active,
	input wire xfer_abort,
	input wire [47:0] xfer_lba,
	input wire [16:0] xfer_sectors,
	input wire continuous,
	input wire intrq
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	reg [16:0] seen_q;
	wire [16:0] seen_d = xfer_active ? seen_q + {16'h0, sector_ok | sector_err} : 17'h0;
	always @(posedge clk) seen_q <= reset ? 17'h0 : seen_d;
	sequence s_fall; $fell(xfer_active); endsequence
	sequence s_irq; ##1 intrq; endsequence
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready");
	lba_step_a: assert property (xfer_active && (sector_ok || sector_err) |=>
		xfer_lba == $past(xfer_lba) + 48'h1) else $error("lba step");
	abort_drop_a: assert property (xfer_abort |-> s_fall) else $error("abort without stop");
	rc_keep_a: assert property (xfer_active && continuous && sector_err |=> !xfer_abort)
		else $error("continuous abort");
	err_halt_a: assert property (xfer_active && !continuous && sector_err |-> ##[1:2] xfer_abort)
		else $error("no halt");
	done_irq_a: assert property (s_fall |-> s_irq) else $error("no intrq");
	count_range_a: assert property ($rose(xfer_active) |-> xfer_sectors != 17'h0 &&
		xfer_sectors <= 17'h10000) else $error("count");
	full_run_a: assert property (s_fall and !xfer_abort |-> seen_q == xfer_sectors)
		else $error("short transfer");
endmodule // rscc_asserts
bind read_stream_command_control rscc_asserts #(.MIN_CCTL_US(MIN_CCTL_US)) u_chk (.clk(clk), .reset(reset),
	.hreadyout(hreadyout), .hresp(hresp), .sector_ok(sector_ok), .sector_err(sector_err),
	.xfer_active(xfer_active), .xfer_abort(xfer_abort), .xfer_lba(xfer_lba),
	.xfer_sectors(xfer_sectors), .continuous(continuous), .intrq(intrq));

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
	reg clk = 1'h0, reset = 1'h1, hsel = 1'h0, hwrite = 1'h0;
	reg [1:0] htrans = 2'h0;
	reg [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'hea7f18bb, r;
	reg [16:0] bad_lo = 17'h0, bad_hi = 17'h0;
	reg [7:0] gap = 8'h3, f, k;
	reg [3:0] kind = 4'h0;
	reg [47:0] lba;
	reg [63:0] ex;
	reg [15:0] n;
	integer miscompares = 0, total_checks = 0, i, h, t;
	wire [31:0] hrdata;
	wire hreadyout, hresp, sector_ok, sector_err, xfer_active, xfer_abort, continuous, intrq;
	wire [3:0] err_kind;
	wire [47:0] xfer_lba;
	wire [16:0] xfer_sectors;
	wire [2:0] stream_id;
	always #20 clk = ~clk;
	read_stream_command_control #(.MIN_CCTL_US(24'h000002)) u_dut (.clk(clk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sector_ok(sector_ok), .sector_err(sector_err),
		.err_kind(err_kind), .xfer_active(xfer_active), .xfer_abort(xfer_abort), .xfer_lba(xfer_lba),
		.xfer_sectors(xfer_sectors), .stream_id(stream_id), .urgent(), .continuous(continuous),
		.not_sequential(), .resume_recovery(), .intrq(intrq));
	media_model u_media (.clk(clk), .reset(reset), .xfer_active(xfer_active), .gap(gap), .bad_lo(bad_lo),
		.bad_hi(bad_hi), .kind(kind), .sector_ok(sector_ok), .sector_err(sector_err), .err_kind(err_kind));
	function [31:0] lfsr(input [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function [7:0] ekb(input [3:0] q);
		ekb = {q[3], q[2], 1'h0, q[1], 1'h0, q[0], 2'h0};
	endfunction
	task stop_test;
		begin
			$display("checks %0d miscompares %0d", total_checks, miscompares);
			if (miscompares == 0 && total_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task chk(input [47:0] g, input [47:0] e);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("[ERR] %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	// drives change on the edge by nonblocking assignment; reads here see what stood before it
	task tick;
		begin
			@(posedge clk);
			t = t + 1;
			if (t > 20000) begin
				miscompares = miscompares + 1;
				$display("[ERR] %0t wait timed out", $time);
				stop_test;
			end
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		begin
			hsel <= 1'h1;
			haddr <= {24'h0, a};
			hwrite <= w;
			htrans <= 2'h2;
			t = 0;
			tick;
			while (hreadyout !== 1'h1) tick;
			htrans <= 2'h0;
			hwdata <= d;
			tick;
			while (hreadyout !== 1'h1) tick;
			r = hrdata;
		end
	endtask
	task cmd(input [7:0] fp, input [7:0] fc);
		begin
			bus(1'h1, 8'h04, fp);
			bus(1'h1, 8'h04, fc);
			bus(1'h1, 8'h08, n[15:8]);
			bus(1'h1, 8'h08, n[7:0]);
			for (k = 0; k < 3; k = k + 1) begin
				bus(1'h1, 8'h0c + {k[5:0], 2'h0}, lba[24 + 8 * k +: 8]);
				bus(1'h1, 8'h0c + {k[5:0], 2'h0}, lba[8 * k +: 8]);
			end
			bus(1'h1, 8'h18, 32'he0);
			bus(1'h1, 8'h00, 32'h2b);
		end
	endtask
	task wait_done;
		begin
			t = 0;
			while (intrq !== 1'h1) tick;
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		bus(1'h0, 8'h24, 0);
		chk(r[7:0], 8'h40);
		bus(1'h1, 8'h3c, 32'hff);
		bus(1'h0, 8'h3c, 0);
		chk(r, 0);
		bus(1'h1, 8'h18, 0);
		bus(1'h1, 8'h00, 32'h2b);
		tick;
		chk(xfer_active, 0);
		for (i = 0; i < 10; i = i + 1) begin
			seed = lfsr(seed);
			lba = {seed[15:0], lfsr(seed)};
			n = {13'h0, seed[2:0]} + 16'h1;
			bad_lo = (i > 1) ? {14'h0, seed[18:16]} % {1'h0, n} : 17'h1ffff;
			bad_hi = bad_lo + {16'h0, seed[20]} + 17'h1;
			kind = 4'h1 << (i / 2 % 4);
			f = {seed[7], i[0], seed[5:4], 1'h0, seed[10:8]};
			cmd(8'h0, f);
			tick;
			chk(xfer_lba, lba);
			chk(xfer_sectors, n);
			chk({stream_id, continuous}, {f[2:0], f[6]});
			wait_done;
			bus(1'h0, 8'h24, 0);
			chk(r[7:0], {2'h1, i[0] && i > 1, 4'h0, !i[0] && i > 1});
			bus(1'h0, 8'h20, 0);
			chk(r[7:0], (i[0] || i < 2) ? 8'h0 : ekb(kind));
			bus(1'h0, 8'h30, 0);
			if (i[0]) chk(r[7:0], (i > 1) ? ekb(kind) : 8'h0);
			ex[63:16] = lba + {31'h0, bad_lo};
			ex[15:0] = (bad_hi > {1'h0, n}) ? n - bad_lo[15:0] : bad_hi[15:0] - bad_lo[15:0];
			ex = {ex[63:56], ex[39:32], ex[55:48], ex[31:24], ex[47:40], ex[23:0]};
			for (h = 0; h < 2 && i > 1; h = h + 1) begin
				bus(1'h1, 8'h1c, {h[0], 7'h0});
				for (k = i[0] ? 0 : 1; k < 4; k = k + 1) begin
					bus(1'h0, 8'h08 + {k[5:0], 2'h0}, 0);
					chk(r[7:0], ex[16 * k + 8 * h +: 8]);
				end
			end
			bus(1'h1, 8'h1c, 0);
			$display("cmd %0d done", i);
		end
		gap = 8'h0;
		n = 16'h0;
		for (i = 0; i < 2; i = i + 1) begin
			bus(1'h1, 8'h28, i ? 1 : 3);
			bus(1'h1, 8'h2c, 32'h501);
			cmd(i ? 8'h0 : 8'h1, {1'h1, i[0], 6'h5});
			tick;
			chk(xfer_sectors, 17'h10000);
			wait_done;
			chk(t >= (i ? 48 : 73) && t <= (i ? 54 : 79), 1);
			bus(1'h0, 8'h24, 0);
			chk(r[7:0], i ? 8'h60 : 8'h41);
			bus(1'h0, 8'h20, 0);
			chk(r[7:0], i ? 8'h0 : 8'h1);
			bus(1'h0, 8'h30, 0);
			if (i) chk(r[7:0], 8'h1);
			$display("timeout %0d done", i);
		end
		stop_test;
	end
endmodule // tb
